// File: rtl/sac_pkg.sv
// Shared constants and types for the SAR converter control block
package sac_pkg;

  // Result bus widths of the two resolution variants
  localparam int DATA_W_LO = 10;
  localparam int DATA_W_HI = 12;

  // Control clock
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_PS = 5000;

  // Wake-up interval after leaving sleep, least time, rounded up
  localparam int WAKE_TIME_US = 1;
  localparam int WAKE_CYC =
    (WAKE_TIME_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_CNT_W = 8;
  localparam logic [WAKE_CNT_W-1:0] WAKE_LOAD = 8'(WAKE_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST = 8'h00;

  // Conversion clock edges spent beyond one per result bit:
  // one to settle the sampled charge, one to hand the code over
  localparam int SAR_EXTRA_STEPS = 2;
  localparam int SAR_CNT_W = 4;
  localparam logic [SAR_CNT_W-1:0] SAR_CNT_RST = 4'hF;

  // Reset values of pin samplers and result bits
  localparam logic START_IDLE = 1'b1;
  localparam logic CONV_CLK_IDLE = 1'b0;
  localparam logic RESULT_RST_BIT = 1'b0;

  typedef enum logic [2:0] {
    ST_READY,
    ST_CONVERT,
    ST_FINISH,
    ST_SLEEP,
    ST_WAKE
  } sac_state_t;

endpackage : sac_pkg

// File: rtl/sac_sar_if.sv
// Signals between the sequencer and the approximation register
interface sac_sar_if #(
  parameter int W = 12
) ();
  logic clear;
  logic step;
  logic cmp_hi;
  logic done;
  logic [W-1:0] trial;
  logic [W-1:0] code;

  modport sar (input clear, input step, input cmp_hi,
               output done, output trial, output code);
  modport ctl (output clear, output step, output cmp_hi,
               input done, input trial, input code);
endinterface : sac_sar_if

// File: rtl/sac_sar.sv
// Successive-approximation register, one decision per conversion clock
module sac_sar #(
  parameter int W = sac_pkg::DATA_W_HI
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sequencer side
  sac_sar_if.sar bus
);
  import sac_pkg::*;

  localparam logic [SAR_CNT_W-1:0] LAST_BIT = SAR_CNT_W'(W);
  localparam logic [SAR_CNT_W-1:0] HANDOVER = SAR_CNT_W'(W + 1);

  logic [SAR_CNT_W-1:0] cnt;
  logic [W-1:0] code;
  logic done;

  function automatic logic [W-1:0] bit_mask(input logic [SAR_CNT_W-1:0] c);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < W; i++) begin
      if (SAR_CNT_W'(W - i) == c) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  wire deciding = (cnt != '0) && (cnt <= LAST_BIT);
  wire [W-1:0] cur_mask = deciding ? bit_mask(cnt) : '0;
  // Comparator high means input is at or above the trial level, so the
  // bit is kept: plain unsigned code, transitions on whole LSBs
  wire [W-1:0] next_code = bus.cmp_hi ? code : (code & ~cur_mask);
  wire [W-1:0] trial = code | cur_mask;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= SAR_CNT_RST;
      code <= {W{RESULT_RST_BIT}};
      done <= 1'b0;
    end else if (bus.clear) begin
      cnt <= '0;
      code <= {W{RESULT_RST_BIT}};
      done <= 1'b0;
    end else begin
      done <= bus.step && (cnt == HANDOVER);
      if (bus.step && (cnt <= HANDOVER)) begin
        cnt <= cnt + 1'b1;
      end
      if (bus.step && deciding) begin
        code <= next_code | (trial & cur_mask & {W{bus.cmp_hi}});
      end
    end
  end

  assign bus.trial = trial;
  assign bus.code = code;
  assign bus.done = done;
endmodule // sac_sar

// File: rtl/sac_bus_drv.sv
// Result register and three-state enable for the parallel read bus
module sac_bus_drv #(
  parameter int W = sac_pkg::DATA_W_HI
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Completed result
  input wire logic load,
  input wire logic [W-1:0] result,
  // Host read strobes
  input wire logic cs_n,
  input wire logic rd_n,
  // Data pins
  output logic [W-1:0] data_out,
  output logic data_oe
);
  import sac_pkg::*;

  // Held until the next completed conversion, so reads repeat
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= {W{RESULT_RST_BIT}};
    end else if (load) begin
      data_out <= result;
    end
  end

  // Enable is combinational so the pins float the moment a strobe rises
  assign data_oe = !cs_n && !rd_n;
endmodule // sac_bus_drv

// File: rtl/sac_adc_ctl.sv
// Conversion sequencing, sleep/wake control and parallel readout
//
// Function
// - Result bus is 10 or 12 bits.
// - Drive data only with select and read low.
// - Float data when select or read rises.
// - Result appears just before busy falls.
// - Start level at end picks operating mode.
// - Start fall while busy restarts conversion.
// - Start low when busy falls enters sleep.
// - Start rising edge wakes a sleeping device.
// - Conversion waits out the wake-up interval.
// - Busy rises only after a start fall.
// - Approximation starts on first clock after busy.
// - Start fall samples input, busy during conversion.
// - Results are straight unsigned binary.
module sac_adc_ctl #(
  parameter int DATA_W = sac_pkg::DATA_W_HI
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Conversion control from host
  input wire logic conversion_start_n,
  input wire logic conv_clk,
  output logic busy,
  // Parallel read bus
  input wire logic cs_n,
  input wire logic rd_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Analog front end
  input wire logic cmp_hi,
  output logic [DATA_W-1:0] dac_code,
  output logic hold,
  output logic sleep
);
  import sac_pkg::*;

  sac_state_t state;
  sac_state_t next_state;
  logic start_q;
  logic conv_clk_q;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic wake_pend;

  sac_sar_if #(.W(DATA_W)) sar_bus ();

  // Edge detection on the host pins, which arrive synchronous
  wire start_fall = start_q && !conversion_start_n;
  wire start_rise = !start_q && conversion_start_n;
  wire clk_rise = !conv_clk_q && conv_clk;

  wire in_busy = (state == ST_CONVERT) || (state == ST_FINISH);
  wire wake_done = (state == ST_WAKE) && (wake_cnt == '0);

  // A fall while converting restarts; fall in ready starts at once;
  // a fall during wake-up is held until the interval is over
  wire restart = in_busy && start_fall;
  wire go_ready = (state == ST_READY) && start_fall;
  wire go_wake = wake_done && (wake_pend || start_fall);
  wire launch = go_ready || go_wake || restart;

  // Clock edges count only once busy is already high, so the edge that
  // coincides with the start never becomes a decision
  wire sar_step = clk_rise && (state == ST_CONVERT) && !restart;

  always_comb begin
    next_state = state;
    case (state)
      ST_READY: begin
        if (go_ready) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (restart) begin
          next_state = ST_CONVERT;
        end else if (sar_bus.done) begin
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (restart) begin
          next_state = ST_CONVERT;
        end else if (conversion_start_n) begin
          next_state = ST_READY;
        end else begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (start_rise) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (go_wake) begin
          next_state = ST_CONVERT;
        end else if (wake_done) begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_READY;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_READY;
      start_q <= START_IDLE;
      conv_clk_q <= CONV_CLK_IDLE;
    end else begin
      state <= next_state;
      start_q <= conversion_start_n;
      conv_clk_q <= conv_clk;
    end
  end

  // Wake-up timer loads on the waking edge and runs down to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt <= WAKE_CNT_RST;
    end else if ((state == ST_SLEEP) && start_rise) begin
      wake_cnt <= WAKE_LOAD;
    end else if ((state == ST_WAKE) && (wake_cnt != '0)) begin
      wake_cnt <= wake_cnt - 1'b1;
    end
  end

  // A start fall during wake-up is remembered; a fall in the very
  // cycle the timer ends is taken directly by go_wake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_pend <= 1'b0;
    end else if ((state == ST_WAKE) && start_fall && !wake_done) begin
      wake_pend <= 1'b1;
    end else if (state != ST_WAKE) begin
      wake_pend <= 1'b0;
    end
  end

  assign sar_bus.clear = launch;
  assign sar_bus.step = sar_step;
  assign sar_bus.cmp_hi = cmp_hi;

  sac_sar #(.W(DATA_W)) u_sar (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(sar_bus.sar)
  );

  // The result loads on done while busy stays high through the finish
  // state, so the bus shows the new code one cycle before busy falls
  sac_bus_drv #(.W(DATA_W)) u_drv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(sar_bus.done),
    .result(sar_bus.code),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .data_out(data_out),
    .data_oe(data_oe)
  );

  // Busy also holds the track/hold; the front end must not be disturbed
  // by bus activity then, which is left to the host
  assign busy = in_busy;
  assign hold = in_busy;
  assign sleep = (state == ST_SLEEP);
  assign dac_code = sar_bus.trial;

  // Helper logic for the checks below
  logic [WAKE_CNT_W:0] wake_age;
  logic [SAR_CNT_W-1:0] step_seen;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_age <= '0;
    end else if (state == ST_WAKE) begin
      wake_age <= wake_age + 1'b1;
    end else begin
      wake_age <= '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_seen <= '0;
    end else if (launch) begin
      step_seen <= '0;
    end else if (sar_step) begin
      step_seen <= step_seen + 1'b1;
    end
  end

  localparam logic [WAKE_CNT_W:0] WAKE_AGE_END = 9'(WAKE_CYC);
  localparam logic [SAR_CNT_W-1:0] STEPS_PER_CONV =
    SAR_CNT_W'(DATA_W + SAR_EXTRA_STEPS);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_bus_width:
    assert property ((DATA_W == DATA_W_LO) || (DATA_W == DATA_W_HI))
    else $error("result bus width is not a documented variant");

  a_bus_drive:
    assert property (!cs_n && !rd_n |-> data_oe)
    else $error("data not driven with select and read low");

  a_bus_release:
    assert property ((cs_n || rd_n) |-> !data_oe)
    else $error("data still driven after a strobe went high");

  a_data_early:
    assert property (sar_bus.done && !restart |=>
      (data_out == $past(sar_bus.code)) && busy
      ##1 (!busy || $past(start_fall)))
    else $error("result not on bus one cycle before busy fell");

  a_mode_pick:
    assert property ($fell(busy) |->
      ((state == ST_SLEEP) == !$past(conversion_start_n)))
    else $error("mode at end of conversion does not follow start level");

  a_abort_restart:
    assert property (restart |=> busy && (step_seen == '0)
      && !sar_bus.done)
    else $error("start fall while busy did not restart conversion");

  a_wake_edge:
    assert property ((state == ST_SLEEP) && start_rise |=>
      (state == ST_WAKE) && !busy)
    else $error("rising start did not begin wake-up");

  a_wake_length:
    assert property ($past(state) == ST_WAKE && state != ST_WAKE |->
      wake_age == WAKE_AGE_END)
    else $error("wake-up interval has the wrong length");

  a_busy_cause:
    assert property ($rose(busy) |->
      $past(start_fall) || $past(wake_pend))
    else $error("busy rose without a start fall");

  a_step_busy:
    assert property (sar_step |-> busy && ($past(busy) || $past(launch)))
    else $error("approximation stepped before busy was high");

  a_conv_steps:
    assert property (sar_bus.done |-> step_seen == STEPS_PER_CONV)
    else $error("conversion took the wrong number of clock edges");

  a_result_hold:
    assert property (!sar_bus.done |=> $stable(data_out))
    else $error("result changed without a completed conversion");

  a_ready_start:
    assert property ((state == ST_READY) && start_fall |=> busy && hold)
    else $error("start fall in ready state did not raise busy");

  a_launch_clear:
    assert property (launch |=> (dac_code == '0) && !sar_bus.done)
    else $error("approximation register not cleared at a start");

  a_fast_return:
    assert property ((state == ST_FINISH) && !restart && conversion_start_n
      |=> (state == ST_READY) && !sleep)
    else $error("high start at end of conversion did not stay awake");

  a_sleep_stay:
    assert property ((state == ST_SLEEP) && !start_rise |=> sleep && !busy)
    else $error("sleep left without a rising start");

  a_wake_wait:
    assert property ((state == ST_WAKE) && (wake_cnt != '0) |=> !busy)
    else $error("conversion began inside the wake-up interval");

  a_pend_launch:
    assert property (wake_done && wake_pend |=> busy && (step_seen == '0))
    else $error("held start did not launch after wake-up");

  c_fast_mode:
    cover property ($fell(busy) && state == ST_READY);
  c_sleep_mode:
    cover property ($fell(busy) && state == ST_SLEEP);
  c_restart:
    cover property (restart && state == ST_FINISH);
  c_wake_pending:
    cover property (go_wake && wake_pend);
  c_wake_idle:
    cover property (wake_done && !wake_pend && !start_fall);
endmodule // sac_adc_ctl

// File: verif/sac_afe_model.sv
// Analog front end and conversion clock source facing the converter block
module sac_afe_model #(
  parameter int W = 12
) (
  // Clock and mode
  input wire logic ref_clk,
  input wire logic burst,
  // Converter side
  input wire logic busy,
  input wire logic [W-1:0] vin,
  input wire logic [W-1:0] dac_code,
  output logic cmp_hi,
  output logic conv_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;
  // Ideal comparator on a straight binary scale
  assign cmp_hi = (vin >= dac_code);
  // Burst clock is gated by busy, so it stands low between conversions
  always @(posedge ref_clk) begin
    div <= div + 2'h1;
    conv_clk <= #1 (burst && !busy) ? 1'b0 : div[1];
  end
endmodule // sac_afe_model

// File: verif/testbench.sv
// Self-checking bench for the converter control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;
  localparam int W = DATA_W_HI;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_n = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic burst = 1'b0;
  logic [W-1:0] vin = '0;
  logic conv_clk, busy, data_oe, cmp_hi, hold, sleep;
  logic [W-1:0] data_out, dac_code, prev;
  wire [W-1:0] data_bus = data_oe ? data_out : 'z;
  int error_cnt = 0;
  int num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  sac_adc_ctl #(.DATA_W(W)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .conversion_start_n(start_n), .conv_clk(conv_clk), .busy(busy),
    .cs_n(cs_n), .rd_n(rd_n), .data_out(data_out), .data_oe(data_oe),
    .cmp_hi(cmp_hi), .dac_code(dac_code), .hold(hold), .sleep(sleep));
  sac_afe_model #(.W(W)) i_afe (.ref_clk(ref_clk), .burst(burst),
    .busy(busy), .vin(vin), .dac_code(dac_code), .cmp_hi(cmp_hi),
    .conv_clk(conv_clk));

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [W-1:0] exp, got);
    num_checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      step(1);
      n++;
    end
    if (busy !== lvl) begin
      error_cnt++;
      $display("[FAIL] busy wait expected %b seen %b", lvl, busy);
      test_done();
    end
  endtask

  task automatic read(input logic [W-1:0] exp);
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(1);
    chk("read data", exp, data_bus);
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(1);
  endtask

  // Gap after busy falls keeps the acquisition time
  task automatic convert(input logic [W-1:0] v, input logic keep_low);
    vin = v;
    start_n = 1'b0;
    wait_busy(1'b1, 4);
    chk("hold", W'(1), W'(hold));
    if (!keep_low) start_n = 1'b1;
    wait_busy(1'b0, 300);
    step(30);
  endtask

  task automatic t_bus();
    logic [1:0] sel;
    convert(12'hA5C, 1'b0);
    chk("bus width", W'(DATA_W_HI), W'($bits(data_out)));
    for (int i = 0; i < 4; i++) begin
      sel = 2'(i);
      cs_n = sel[1];
      rd_n = sel[0];
      step(1);
      chk("bus drive", (|sel) ? 12'hZZZ : 12'hA5C, data_bus);
    end
    cs_n = 1'b1;
    rd_n = 1'b1;
    read(12'hA5C);
    read(12'hA5C);
  endtask

  task automatic t_fast();
    convert(12'h3FF, 1'b0);
    chk("sleep fast", W'(0), W'(sleep));
    read(12'h3FF);
    burst = 1'b1;
    convert(12'hFFF, 1'b0);
    read(12'hFFF);
    convert(12'h000, 1'b0);
    read(12'h000);
    burst = 1'b0;
  endtask

  task automatic t_tied();
    cs_n = 1'b0;
    rd_n = 1'b0;
    vin = 12'h5A3;
    start_n = 1'b0;
    wait_busy(1'b1, 4);
    start_n = 1'b1;
    for (int n = 0; n < 300 && busy === 1'b1; n++) begin
      prev = data_bus;
      step(1);
    end
    chk("early data", 12'h5A3, prev);
    chk("tied busy end", W'(0), W'(busy));
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(30);
  endtask

  task automatic t_restart();
    vin = 12'h111;
    start_n = 1'b0;
    wait_busy(1'b1, 4);
    start_n = 1'b1;
    step(20);
    vin = 12'h7E4;
    start_n = 1'b0;
    step(1);
    chk("restart clear", 12'h000, dac_code);
    start_n = 1'b1;
    wait_busy(1'b0, 300);
    step(30);
    read(12'h7E4);
  endtask

  task automatic t_sleep();
    int n;
    convert(12'h800, 1'b1);
    chk("sleep entry", W'(1), W'(sleep));
    step(10);
    chk("busy asleep", W'(0), W'(busy));
    start_n = 1'b1;
    step(1);
    start_n = 1'b0;
    n = 1;
    while (busy !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    chk("wake wait", W'(1), W'(n >= WAKE_CYC && n <= WAKE_CYC + 4));
    start_n = 1'b1;
    wait_busy(1'b0, 300);
    step(30);
    read(12'h800);
  endtask

  initial begin
    step(12);
    rst_n = 1'b1;
    step(2);
    convert(12'h000, 1'b0);
    t_bus();
    t_fast();
    t_tied();
    t_restart();
    t_sleep();
    test_done();
  end
endmodule // testbench
